/* hw/dda_device.sv */
// Implementation choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
// Contract
// - Attention pin = condition AND gating enable
// - Only clear commands reset attention condition
// - Clear-fault resets errors; clear-attention clears unless a set lands in the same cycle
// - One index pulse per revolution when ready
// - Sector pulse suppressed during index pulse
// - One address-mark rise per control assertion
// - Write gate plus mark control writes mark
// - No recording without write enable set
// - Read data static while read gate off
// - Clock out: read clock or reference clock
// - Two-byte commands; parameter follows direction line
// - Codes 80-FF set attention, illegal bit
// - No-parameter commands return general status
// - Immediate ack after action; failure attention first
// - Time-dependent ends attention; clear completes it
// - Time-dependent during busy-exec is rejected
// - Immediate commands accepted during busy-exec
// - Attention control gates party line only
// - Write control sets or clears write enable
// - Busy falling edge sets attention
// - Attention-in strobe drives own bus bit
module dda_device
    import dda_pkg::*;
#(
    parameter int DEV_ID = 0
)(
    input wire logic clk,
    input wire logic srst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire dda_host_t hostIn,
    input wire dda_media_t mediaIn,
    output logic [7:0] ctrlBusOut,
    output logic ctrlBusOe_n,
    output logic busAck,
    output logic busyOut,
    output logic attentionOut,
    output logic indexOut,
    output logic sectorAmOut,
    output logic readDataOut,
    output logic rrClkOut,
    output logic recordOut,
    output logic recordData,
    output logic amWriteOut
);

    ////////////////////////////////////////////////////////////////////
    // Synchronisers

    // Two stages for every asynchronous pin, plus a history stage
    dda_host_t hostS1, hostS2, hostP;
    dda_media_t mediaS1, mediaS2, mediaP;

    // First stage feeds only the second stage
    always_ff @(posedge clk)
    begin
        hostS1 <= hostIn;
        hostS2 <= hostS1;
        hostP <= hostS2;
        mediaS1 <= mediaIn;
        mediaS2 <= mediaS1;
        mediaP <= mediaS2;
    end

    ////////////////////////////////////////////////////////////////////
    // Register file over AHB-Lite

    logic [2:0] ctrl_reg; // Ready, carriage moving, fail inject
    logic [15:0] tdCycles_reg; // Duration of time-dependent actions
    logic dValid; // Write data phase pending
    logic [7:0] dAddr; // Latched write offset
    logic [31:0] statusWord; // Assembled status for reads
    logic [31:0] rdNext; // Read mux
    logic addrPhase; // Valid transfer in address phase

    assign addrPhase = hsel && htrans[1] && hready;

    // Read mux; unmapped offsets read zero
    always_comb
    begin
        rdNext = 32'h0000_0000;
        case (haddr[7:0])
            ADDR_CTRL: rdNext = {29'h0000_0000, ctrl_reg};
            ADDR_STATUS: rdNext = statusWord;
            ADDR_TDCYC: rdNext = {16'h0000, tdCycles_reg};
            default: rdNext = 32'h0000_0000;
        endcase
    end

    // Zero wait states: data phase always completes in one cycle
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            dValid <= 1'b0;
            dAddr <= 8'h00;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else
        begin
            dValid <= addrPhase && hwrite;
            dAddr <= haddr[7:0];
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            // Read data stands in the data phase
            if (addrPhase && !hwrite)
                hrdata <= rdNext;
        end
    end

    // Register writes land in the data phase
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            ctrl_reg <= CTRL_RST;
            tdCycles_reg <= TD_CYCLES_RST;
        end
        else if (dValid)
        begin
            if (dAddr == ADDR_CTRL)
                ctrl_reg <= hwdata[2:0];
            else if (dAddr == ADDR_TDCYC)
                tdCycles_reg <= hwdata[15:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Selection

    logic selected; // Device selected on the control bus

    // Select strobe edge with direction outbound picks our bus bit
    always_ff @(posedge clk)
    begin
        if (srst)
            selected <= 1'b0;
        else if (hostS2.selStrobe && !hostP.selStrobe && hostS2.busDirOut)
            selected <= hostS2.ctrlBus[DEV_ID];
    end

    ////////////////////////////////////////////////////////////////////
    // Command handshake

    typedef enum logic [2:0] {S_IDLE, S_CMD_ACK, S_PAR_WAIT, S_EXEC, S_PAR_ACK} dda_state_t;
    dda_state_t state;
    logic [7:0] cmdByte; // Latched command byte
    logic [7:0] parByte; // Latched parameter byte
    logic parIn; // Parameter goes to the host
    logic [3:0] execCnt; // Action time for every command before the second ack
    logic execNow; // Action completes this cycle
    logic isTd; // Command is time-dependent

    // Status state
    logic attnCond, attnEnable, writeEnable;
    logic illegalCmd, faultBit, cmdReject, busyExec, busyLine;
    logic [15:0] tdCnt;
    logic attnSet, attnClr, errClr;
    logic [7:0] genStatus;

    assign execNow = (state == S_EXEC) && (execCnt == 4'h0);
    assign isTd = (cmdByte == CMD_SEL_RST) || (cmdByte == CMD_LANDING) ||
        (cmdByte == CMD_PARTITION) || (cmdByte == CMD_HEAD_TD) ||
        (cmdByte == CMD_OFFSET) || (cmdByte == CMD_SPIN);

    // Handshake sequencer, two bytes per command
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state <= S_IDLE;
            cmdByte <= 8'h00;
            parByte <= 8'h00;
            parIn <= 1'b0;
            execCnt <= 4'h0;
        end
        else
        begin
            case (state)
                // Wait for request; hold off while busy line is up
                S_IDLE:
                begin
                    if (selected && hostS2.cmdReq && hostS2.busDirOut && !busyLine)
                    begin
                        cmdByte <= hostS2.ctrlBus;
                        state <= S_CMD_ACK;
                    end
                end
                // Host drops request after seeing ack
                S_CMD_ACK:
                begin
                    if (!hostS2.cmdReq)
                        state <= S_PAR_WAIT;
                end
                // Parameter request, direction decides who drives
                S_PAR_WAIT:
                begin
                    if (hostS2.parReq)
                    begin
                        parIn <= !hostS2.busDirOut;
                        parByte <= hostS2.ctrlBus;
                        execCnt <= 4'(EXEC_CYCLES - 1);
                        state <= S_EXEC;
                    end
                end
                // Action time before the second ack
                S_EXEC:
                begin
                    if (execCnt == 4'h0)
                        state <= S_PAR_ACK;
                    else
                        execCnt <= execCnt - 4'h1;
                end
                S_PAR_ACK:
                begin
                    if (!hostS2.parReq)
                        state <= S_IDLE;
                end
                default: state <= S_IDLE;
            endcase
        end
    end

    // Ack trails the state by one cycle so attention and busy lead it
    always_ff @(posedge clk)
    begin
        if (srst)
            busAck <= 1'b0;
        else
            busAck <= (state == S_CMD_ACK) || (state == S_PAR_ACK);
    end

    ////////////////////////////////////////////////////////////////////
    // Command execution and attention

    logic tdDone; // Last busy cycle; the busy line drops at this edge
    logic rejectNow; // New time-dependent refused
    logic failNow; // Immediate action failed

    assign tdDone = busyLine && (tdCnt == 16'h0000);

    // Set and clear causes, evaluated together
    always_comb
    begin
        rejectNow = 1'b0;
        failNow = 1'b0;
        attnSet = 1'b0;
        attnClr = 1'b0;
        errClr = 1'b0;
        if (execNow)
        begin
            if (cmdByte[CMD_RESERVED_BIT])
                attnSet = 1'b1;
            else if (isTd && busyExec)
                rejectNow = 1'b1;
            else if (!isTd && ctrl_reg[CTRL_FAIL])
                failNow = 1'b1;
            if (cmdByte == CMD_CLR_ATTN)
                attnClr = 1'b1;
            if (cmdByte == CMD_CLR_FAULT)
            begin
                attnClr = 1'b1;
                errClr = 1'b1;
            end
        end
        if (tdDone)
            attnSet = 1'b1;
        if (rejectNow || failNow)
            attnSet = 1'b1;
    end

    // Attention condition; a set in the clearing cycle wins
    always_ff @(posedge clk)
    begin
        if (srst)
            attnCond <= 1'b0;
        else
            attnCond <= attnSet || (attnCond && !attnClr);
    end

    // Error bits; set beats clear-fault
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            illegalCmd <= 1'b0;
            faultBit <= 1'b0;
            cmdReject <= 1'b0;
        end
        else
        begin
            illegalCmd <= (execNow && cmdByte[CMD_RESERVED_BIT]) || (illegalCmd && !errClr);
            faultBit <= failNow || (faultBit && !errClr);
            cmdReject <= rejectNow || (cmdReject && !errClr);
        end
    end

    // Gating and write enable from their control commands
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            attnEnable <= 1'b1;
            writeEnable <= 1'b0;
        end
        else if (execNow && !parIn)
        begin
            if (cmdByte == CMD_ATTN_CTL)
                attnEnable <= parByte[PAR_ENABLE];
            if (cmdByte == CMD_WRITE_CTL)
                writeEnable <= parByte[PAR_ENABLE];
        end
    end

    // Time-dependent action: busy line for a while, busy-exec until cleared
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            busyExec <= 1'b0;
            busyLine <= 1'b0;
            tdCnt <= 16'h0000;
        end
        else if (execNow && isTd && !busyExec && !cmdByte[CMD_RESERVED_BIT])
        begin
            busyExec <= 1'b1;
            busyLine <= 1'b1;
            tdCnt <= tdCycles_reg;
        end
        else
        begin
            if (busyLine)
                tdCnt <= tdCnt - 16'h0001;
            if (tdDone)
                busyLine <= 1'b0;
            if (busyExec && !busyLine && attnClr)
                busyExec <= 1'b0;
        end
    end

    assign genStatus = {1'b0, busyExec, 3'h0, 1'b0, illegalCmd, faultBit};
    assign statusWord = {16'h0000, 3'h0, cmdReject, writeEnable, attnEnable,
        attnCond, selected, genStatus};

    // Pin outputs for attention and busy
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            attentionOut <= 1'b0;
            busyOut <= 1'b0;
        end
        else
        begin
            attentionOut <= attnCond && attnEnable;
            busyOut <= busyLine;
        end
    end

    // Control bus drive: parameter in, or radial attention
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            ctrlBusOut <= 8'h00;
            ctrlBusOe_n <= 1'b1;
        end
        else if (parIn && (state == S_EXEC || state == S_PAR_ACK))
        begin
            ctrlBusOut <= genStatus;
            ctrlBusOe_n <= 1'b0;
        end
        else if (!hostS2.busDirOut && hostS2.selStrobe)
        begin
            ctrlBusOut <= 8'(attnCond) << DEV_ID;
            ctrlBusOe_n <= 1'b0;
        end
        else
        begin
            ctrlBusOut <= 8'h00;
            ctrlBusOe_n <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Index, sector and address mark

    logic amArmed; // Waiting for a mark this assertion
    logic amOut; // Mark seen this assertion
    logic idxValid; // Selected, ready and carriage still

    assign idxValid = selected && ctrl_reg[CTRL_READY] && !ctrl_reg[CTRL_MOVING];

    // One rising edge per mark-control assertion
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            amArmed <= 1'b0;
            amOut <= 1'b0;
        end
        else if (!hostS2.amCtrl)
        begin
            amArmed <= 1'b0;
            amOut <= 1'b0;
        end
        else
        begin
            if (!hostP.amCtrl)
                amArmed <= 1'b1;
            if (amArmed && hostS2.readGate && mediaS2.amFound)
            begin
                amOut <= 1'b1;
                amArmed <= 1'b0;
            end
        end
    end

    // Index passes the media pulse; sector pin is shared with mark
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            indexOut <= 1'b0;
            sectorAmOut <= 1'b0;
        end
        else
        begin
            indexOut <= idxValid && mediaS2.index;
            if (hostS2.amCtrl && hostS2.readGate)
                sectorAmOut <= amOut;
            else
                sectorAmOut <= idxValid && mediaS2.sector && !mediaS2.index;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read and write paths

    // Sampled clocks only; pulses shorter than one cycle can be lost
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            readDataOut <= 1'b0;
            rrClkOut <= 1'b0;
        end
        else
        begin
            rrClkOut <= hostS2.readGate ? mediaS2.readClk : mediaS2.refClk;
            if (hostS2.readGate && selected && mediaS2.readClk && !mediaP.readClk)
                readDataOut <= mediaS2.readData;
        end
    end

    // Recording needs gate, enable and selection
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            recordOut <= 1'b0;
            recordData <= 1'b0;
            amWriteOut <= 1'b0;
        end
        else
        begin
            recordOut <= hostS2.writeGate && writeEnable && selected;
            amWriteOut <= AM_OPTION && hostS2.writeGate && hostS2.amCtrl &&
                writeEnable && selected;
            if (recordOut && hostS2.writeClk && !hostP.writeClk)
                recordData <= hostS2.writeData;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Assertions

    property p_attn_gate;
        @(posedge clk) disable iff (srst)
        attentionOut |-> $past(attnCond) && $past(attnEnable);
    endproperty
    a_attn_gate: assert property (p_attn_gate) else $error("attention without gate");

    property p_attn_clear;
        @(posedge clk) disable iff (srst)
        $fell(attnCond) |-> $past(execNow) &&
            ($past(cmdByte) == CMD_CLR_ATTN || $past(cmdByte) == CMD_CLR_FAULT);
    endproperty
    a_attn_clear: assert property (p_attn_clear) else $error("attention cleared wrongly");

    property p_sector_idx;
        @(posedge clk) disable iff (srst)
        mediaS2.index && !hostS2.amCtrl |=> !sectorAmOut;
    endproperty
    a_sector_idx: assert property (p_sector_idx) else $error("sector during index");

    property p_am_once;
        @(posedge clk) disable iff (srst)
        amOut && hostS2.amCtrl |=> amOut && !amArmed;
    endproperty
    a_am_once: assert property (p_am_once) else $error("mark rearmed");

    property p_no_record;
        @(posedge clk) disable iff (srst)
        recordOut |-> $past(writeEnable);
    endproperty
    a_no_record: assert property (p_no_record) else $error("record without enable");

    property p_read_static;
        @(posedge clk) disable iff (srst)
        !hostS2.readGate |=> $stable(readDataOut);
    endproperty
    a_read_static: assert property (p_read_static) else $error("read data moved");

    property p_illegal;
        @(posedge clk) disable iff (srst)
        execNow && cmdByte[CMD_RESERVED_BIT] |=> attnCond && illegalCmd ##1 busAck;
    endproperty
    a_illegal: assert property (p_illegal) else $error("reserved code not flagged");

    property p_fail_first;
        @(posedge clk) disable iff (srst)
        failNow |=> attnCond && !busAck ##1 busAck;
    endproperty
    a_fail_first: assert property (p_fail_first) else $error("ack before attention");

    property p_busy_fall;
        @(posedge clk) disable iff (srst)
        $fell(busyLine) |-> attnCond ##1 !busyOut;
    endproperty
    a_busy_fall: assert property (p_busy_fall) else $error("busy fall lost attention");

endmodule : dda_device

/* shared/dda_pkg.sv */
package dda_pkg;
    // Clock and derived timing
    localparam int CLK_MHZ = 40;
    localparam int EXEC_TIME_NS = 200;
    localparam int EXEC_CYCLES = (EXEC_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam logic [15:0] TD_CYCLES_RST = 16'h0400;
    // Register byte offsets on the AHB-Lite slave
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_TDCYC = 8'h08;
    // Control register fields
    localparam int CTRL_READY = 0;
    localparam int CTRL_MOVING = 1;
    localparam int CTRL_FAIL = 2;
    localparam logic [2:0] CTRL_RST = 3'h1;
    // Command codes
    localparam logic [7:0] CMD_CLR_ATTN = 8'h01;
    localparam logic [7:0] CMD_CLR_FAULT = 8'h02;
    localparam logic [7:0] CMD_ATTN_CTL = 8'h40;
    localparam logic [7:0] CMD_WRITE_CTL = 8'h41;
    localparam logic [7:0] CMD_SEL_RST = 8'h14;
    localparam logic [7:0] CMD_LANDING = 8'h15;
    localparam logic [7:0] CMD_PARTITION = 8'h16;
    localparam logic [7:0] CMD_HEAD_TD = 8'h45;
    localparam logic [7:0] CMD_OFFSET = 8'h54;
    localparam logic [7:0] CMD_SPIN = 8'h55;
    localparam int CMD_RESERVED_BIT = 7;
    // General status and sense byte 1 bit positions
    localparam int GS_FAULT = 0;
    localparam int GS_ILLEGAL = 1;
    localparam int GS_BUSY_EXEC = 6;
    localparam int SN1_REJECT = 0;
    // Parameter byte bit for enable/disable commands
    localparam int PAR_ENABLE = 0;
    // Address-mark option present
    localparam bit AM_OPTION = 1'b1;

    // Host-driven pins, logical levels, active high
    typedef struct packed {
        logic busDirOut;
        logic selStrobe;
        logic cmdReq;
        logic parReq;
        logic readGate;
        logic writeGate;
        logic amCtrl;
        logic writeData;
        logic writeClk;
        logic [7:0] ctrlBus;
    } dda_host_t;

    // Media-side inputs from the drive electronics
    typedef struct packed {
        logic index;
        logic sector;
        logic amFound;
        logic readData;
        logic readClk;
        logic refClk;
    } dda_media_t;
endpackage : dda_pkg

/* verification/dda_host_model.sv */
`timescale 1ns/1ps
module dda_host_model
    import dda_pkg::*;
(
    input logic clk,
    input logic busAck,
    input logic refClk,
    input logic [7:0] ctrlBusOut,
    input logic ctrlBusOe_n,
    output dda_host_t hostOut
);
    // Pin levels held between edges
    dda_host_t h = '0;
    // Parameter byte taken at the acknowledge edge
    logic [7:0] rsp;
    ////////////////////////////////////////////////////////////
    // write clock and data move only inside write gate
    always_comb
    begin
        hostOut = h;
        hostOut.writeClk = h.writeGate & refClk;
        hostOut.writeData = h.writeGate & h.writeData;
        // Bus wire shows the device value while it drives
        hostOut.ctrlBus = ctrlBusOe_n ? h.ctrlBus : ctrlBusOut;
    end
    ////////////////////////////////////////////////////////////
    // request held until the acknowledge level is seen
    task wack(input logic v);
        int i;
        i = 0;
        @(posedge clk);
        while (busAck !== v)
        begin
            i++;
            if (i > 500)
                testbench.tmo();
            @(posedge clk);
        end
    endtask : wack
    // command byte out, parameter byte as dOut says
    task xfer(input logic [7:0] cmd, input logic [7:0] par, input logic dOut);
        h.busDirOut <= 1'b1;
        h.ctrlBus <= cmd;
        h.cmdReq <= 1'b1;
        wack(1'b1);
        h.cmdReq <= 1'b0;
        wack(1'b0);
        h.busDirOut <= dOut;
        // Released bus shows a changed level, not the last byte
        h.ctrlBus <= dOut ? par : ~cmd;
        h.parReq <= 1'b1;
        wack(1'b1);
        rsp = ctrlBusOut;
        h.parReq <= 1'b0;
        wack(1'b0);
    endtask : xfer
    // mark control is raised only together with a gate
    task pins(input logic [4:0] p, input logic [7:0] d);
        {h.busDirOut, h.selStrobe, h.readGate, h.writeGate, h.amCtrl} <= p;
        h.ctrlBus <= d;
        repeat (6) @(posedge clk);
    endtask : pins
endmodule : dda_host_model

/* verification/testbench.sv */
`timescale 1ns/1ps
module testbench
    import dda_pkg::*;
;
    logic clk = 0, srst = 1, hsel = 0, hwrite = 0, hresp, hreadyout;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
    dda_host_t hostIn;
    dda_media_t md = '0;
    logic [7:0] cbo;
    logic cboe, ack, busy, attn, idx, secAm, rdo, rrClk, rec, recD, amW;
    int fail_count = 0, checks = 0, n;
    // 40 MHz core clock, 200 ns reference clock
    always #12.5 clk = ~clk;
    always #100 md.refClk = ~md.refClk;
    dda_device u_dda_device (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .hostIn(hostIn), .mediaIn(md), .ctrlBusOut(cbo), .ctrlBusOe_n(cboe),
        .busAck(ack), .busyOut(busy), .attentionOut(attn), .indexOut(idx),
        .sectorAmOut(secAm), .readDataOut(rdo), .rrClkOut(rrClk),
        .recordOut(rec), .recordData(recD), .amWriteOut(amW));
    dda_host_model u_dda_host_model (.clk(clk), .busAck(ack), .refClk(md.refClk),
        .ctrlBusOut(cbo), .ctrlBusOe_n(cboe), .hostOut(hostIn));
    ////////////////////////////////////////////////////////////
    task wrap_up;
        if (fail_count == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up
    task tmo;
        fail_count++;
        $display("ERROR %0t wait bound used up", $time);
        wrap_up();
    endtask : tmo
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task cyc(input int k);
        repeat (k) @(posedge clk);
    endtask : cyc
    // Bounded wait for hready sampled high at an edge
    task hw;
        int i;
        i = 0;
        @(posedge clk);
        while (hreadyout !== 1'b1)
        begin
            i++;
            if (i > 50)
                tmo();
            @(posedge clk);
        end
    endtask : hw
    // One single-word transfer; read data lands in r
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= w;
        hw();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        hw();
        r = hrdata;
    endtask : ahb
    // Sample the clock output eight times, 50 ns apart
    task ones;
        n = 0;
        repeat (8)
        begin
            cyc(2);
            n += int'(rrClk === 1'b1);
        end
    endtask : ones
    ////////////////////////////////////////////////////////////
    task t_sel;
        ahb(1'b0, ADDR_STATUS, 32'h0);
        chk(r, 32'h0000_0400);
        u_dda_host_model.pins(5'b10000, 8'h01);
        u_dda_host_model.pins(5'b11000, 8'h01);
        u_dda_host_model.pins(5'b10000, 8'h01);
        ahb(1'b0, ADDR_STATUS, 32'h0);
        chk(r, 32'h0000_0500);
    endtask : t_sel
    // Reserved code, then radial report, gating and clear-fault
    task t_attn;
        u_dda_host_model.xfer(8'h80, 8'h00, 1'b0);
        chk(u_dda_host_model.rsp[GS_ILLEGAL], 1);
        cyc(4);
        chk(attn, 1);
        u_dda_host_model.pins(5'b01000, 8'h00);
        chk({cboe, cbo[0]}, 2'b01);
        u_dda_host_model.pins(5'b10000, 8'h00);
        u_dda_host_model.xfer(CMD_ATTN_CTL, 8'h00, 1'b1);
        cyc(4);
        chk(attn, 0);
        u_dda_host_model.pins(5'b01000, 8'h00);
        chk(cbo[0], 1);
        u_dda_host_model.pins(5'b10000, 8'h00);
        ahb(1'b1, ADDR_CTRL, 32'h0000_0005);
        u_dda_host_model.xfer(CMD_ATTN_CTL, 8'h01, 1'b1);
        ahb(1'b1, ADDR_CTRL, 32'h0000_0001);
        ahb(1'b0, ADDR_STATUS, 32'h0);
        chk(r, 32'h0000_0703);
        u_dda_host_model.xfer(CMD_CLR_FAULT, 8'h00, 1'b0);
        cyc(4);
        chk(attn, 0);
        ahb(1'b0, ADDR_STATUS, 32'h0);
        chk(r, 32'h0000_0500);
    endtask : t_attn
    task t_write;
        u_dda_host_model.pins(5'b10010, 8'h00);
        chk(rec, 0);
        u_dda_host_model.pins(5'b10000, 8'h00);
        u_dda_host_model.xfer(CMD_WRITE_CTL, 8'h01, 1'b1);
        u_dda_host_model.h.writeData <= 1'b1;
        u_dda_host_model.pins(5'b10010, 8'h00);
        chk(rec, 1);
        u_dda_host_model.pins(5'b10011, 8'h00);
        chk(amW, 1);
        chk(recD, 1);
        u_dda_host_model.pins(5'b10000, 8'h00);
        u_dda_host_model.xfer(CMD_WRITE_CTL, 8'h00, 1'b1);
        u_dda_host_model.pins(5'b10010, 8'h00);
        chk(rec, 0);
        u_dda_host_model.pins(5'b10000, 8'h00);
    endtask : t_write
    // One read clock pulse under read gate, then the read clock held low
    task t_read;
        md.readData <= 1'b1;
        cyc(6);
        chk(rdo, 0);
        ones();
        chk(n > 1 && n < 7, 1);
        u_dda_host_model.pins(5'b10100, 8'h00);
        chk(rdo, 0);
        md.readClk <= 1'b1;
        cyc(4);
        md.readClk <= 1'b0;
        cyc(4);
        chk(rdo, 1);
        ones();
        chk(n, 0);
        u_dda_host_model.pins(5'b10000, 8'h00);
        md.index <= 1'b1;
        md.sector <= 1'b1;
        cyc(6);
        chk({idx, secAm}, 2'b10);
        md.index <= 1'b0;
        cyc(6);
        chk({idx, secAm}, 2'b01);
        md.sector <= 1'b0;
        md.amFound <= 1'b1;
        cyc(4);
        u_dda_host_model.pins(5'b10101, 8'h00);
        chk(secAm, 1);
        u_dda_host_model.pins(5'b10000, 8'h00);
    endtask : t_read
    // Short execution count keeps the run brief
    task t_td;
        ahb(1'b1, ADDR_TDCYC, 32'h0000_0014);
        u_dda_host_model.xfer(CMD_LANDING, 8'h00, 1'b0);
        cyc(30);
        chk(attn, 1);
        u_dda_host_model.xfer(CMD_SPIN, 8'h00, 1'b0);
        ahb(1'b0, ADDR_STATUS, 32'h0);
        chk({r[12], r[GS_BUSY_EXEC]}, 2'b11);
        u_dda_host_model.xfer(CMD_CLR_ATTN, 8'h00, 1'b0);
        cyc(4);
        chk(attn, 0);
        ahb(1'b0, ADDR_STATUS, 32'h0);
        chk(r[GS_BUSY_EXEC], 0);
    endtask : t_td
    ////////////////////////////////////////////////////////////
    initial
    begin
        cyc(4);
        srst <= 1'b0;
        cyc(3);
        t_sel();
        t_attn();
        t_write();
        t_read();
        t_td();
        wrap_up();
    end
endmodule : testbench
